// File: core/nv_pkg.sv
// Shared constants for the byte-wide nonvolatile store and its controller
package nv_pkg;
  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ             = 20_000_000;
  localparam int unsigned OSC_HZ             = 1_000_000;
  localparam int unsigned WRITE_OSC_CYCLES   = 8448;
  localparam int unsigned WRITE_CLK_CYCLES   = WRITE_OSC_CYCLES * (CLK_HZ / OSC_HZ);
  localparam int unsigned ARM_CYCLES         = 4;
  localparam int unsigned WRITE_STALL_CYCLES = 2;
  localparam int unsigned READ_STALL_CYCLES  = 4;
  // ----------------------------------------------------------------
  // Storage and device registers
  // ----------------------------------------------------------------
  localparam int unsigned NV_BYTES         = 512;
  localparam int unsigned ADDR_W           = 9;
  localparam logic [1:0]  OFS_ADDRESS_HIGH = 2'h0;
  localparam logic [1:0]  OFS_ADDRESS_LOW  = 2'h1;
  localparam logic [1:0]  OFS_DATA_BYTE    = 2'h2;
  localparam logic [1:0]  OFS_CONTROL      = 2'h3;
  localparam int unsigned BIT_READ_STROBE  = 0;
  localparam int unsigned BIT_WRITE_STROBE = 1;
  localparam int unsigned BIT_MASTER_ARM   = 2;
  localparam int unsigned BIT_IRQ_ENABLE   = 3;
  localparam logic [8:0]  ADDRESS_RESET    = 9'h000;
  localparam logic [7:0]  DATA_RESET       = 8'h00;
  // ----------------------------------------------------------------
  // Controller registers on the AXI4-Lite side
  // ----------------------------------------------------------------
  localparam logic [7:0]  REG_COMMAND      = 8'h00;
  localparam logic [7:0]  REG_ADDRESS      = 8'h04;
  localparam logic [7:0]  REG_WDATA        = 8'h08;
  localparam logic [7:0]  REG_STATUS       = 8'h0c;
  localparam logic [7:0]  REG_CONFIG       = 8'h10;
  localparam int unsigned CMD_WRITE        = 0;
  localparam int unsigned CMD_READ         = 1;
  localparam int unsigned ST_BUSY          = 0;
  localparam int unsigned ST_IRQ           = 1;
  localparam int unsigned ST_RDATA_LSB     = 8;
  localparam int unsigned CFG_GIE          = 0;
  localparam int unsigned CFG_FLASH_BUSY   = 1;
  localparam int unsigned CFG_IRQ_ENABLE   = 2;
  localparam logic [2:0]  CONFIG_RESET     = 3'h0;
  localparam logic [1:0]  RESP_OKAY        = 2'h0;
  localparam logic [1:0]  RESP_SLVERR      = 2'h2;
endpackage : nv_pkg

// File: core/nv_if.sv
// Register port between the CPU-side controller and the nonvolatile store
`timescale 1ns/100ps
interface nv_if;
  logic [1:0] io_addr;
  logic [7:0] io_wdata;
  logic       io_we;
  logic       io_re;
  logic [7:0] io_rdata;
  logic       cpu_stall;
  logic       ready_irq;
  logic       global_irq_enable;
  logic       flash_store_enable;
  logic       osc_running;

  modport device (
    input  io_addr, io_wdata, io_we, io_re, global_irq_enable, flash_store_enable,
    output io_rdata, cpu_stall, ready_irq, osc_running
  );
  modport cpu (
    output io_addr, io_wdata, io_we, io_re, global_irq_enable, flash_store_enable,
    input  io_rdata, cpu_stall, ready_irq, osc_running
  );
endinterface : nv_if

// File: core/nv_access_device.sv
// Byte-wide nonvolatile store with its access registers and self-timed write
`timescale 1ns/100ps
//
// Function
// - 512 bytes, byte access, 9-bit linear address
// - Address bits 15..9 read zero
// - Address undefined at reset; software loads first
// - Data byte: write source, read destination
// - Control bits 7..4 read zero
// - Ready irq while enabled, global enable, idle
// - Master arm clears four cycles after set
// - Write strobe starts write only when armed
// - Write strobe stays set until write done
// - Write lasts 8448 cycles of 1 MHz
// - Write start stalls CPU two cycles
// - Read strobe loads data, stalls four cycles
// - Busy write blocks reads and address changes
// - No write start while flash programming
// - Software write order, strobe within four cycles
// - Software masks interrupts during write sequence
// - Software polls write strobe before reading
// - Write continues through power-down, oscillator runs
// - Ready irq is level, no latched flag
// - Write completes across system reset
module nv_access_device
  import nv_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = WRITE_CLK_CYCLES
) (
  input  wire logic i_clock,
  input  wire logic i_resetn,
  input  wire logic i_power_resetn,
  input  wire logic i_enable,
  nv_if.device      bus
);

  localparam int unsigned CW = $clog2(WRITE_CYCLES + 1);

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  logic [7:0]        mem_r [NV_BYTES];

  // ----------------------------------------------------------------
  // CPU-side register state
  // ----------------------------------------------------------------
  logic [ADDR_W-1:0] addr_r;
  logic [ADDR_W-1:0] addr_nxt;
  logic [7:0]        data_r;
  logic [7:0]        data_nxt;
  logic              irq_en_r;
  logic              irq_en_nxt;
  logic              arm_r;
  logic              arm_nxt;
  logic [2:0]        arm_cnt_r;
  logic [2:0]        arm_cnt_nxt;
  logic              rd_strobe_r;
  logic              rd_strobe_nxt;
  logic [2:0]        stall_cnt_r;
  logic [2:0]        stall_cnt_nxt;
  logic              stall_r;
  logic              stall_nxt;
  logic              irq_r;
  logic              irq_nxt;
  logic [7:0]        rdata_r;
  logic [7:0]        rdata_nxt;

  // ----------------------------------------------------------------
  // Write engine state, kept across system reset
  // ----------------------------------------------------------------
  logic              busy_r;
  logic              busy_nxt;
  logic [CW-1:0]     wr_cnt_r;
  logic [CW-1:0]     wr_cnt_nxt;
  logic [ADDR_W-1:0] wr_addr_r;
  logic [ADDR_W-1:0] wr_addr_nxt;
  logic [7:0]        wr_data_r;
  logic [7:0]        wr_data_nxt;

  logic              ctrl_wr;
  logic              start_wr;
  logic              start_rd;
  logic              commit;

  // ----------------------------------------------------------------
  // Access decode
  // ----------------------------------------------------------------
  always_comb begin
    ctrl_wr  = bus.io_we && (bus.io_addr == OFS_CONTROL);
    start_wr = ctrl_wr && bus.io_wdata[BIT_WRITE_STROBE] && arm_r
               && !busy_r && !bus.flash_store_enable;
    // Write strobe wins if both strobes are written at once
    start_rd = ctrl_wr && bus.io_wdata[BIT_READ_STROBE] && !busy_r
               && !start_wr;
    commit   = busy_r && (wr_cnt_r == CW'(1));
  end

  // ----------------------------------------------------------------
  // CPU-side registers: next values
  // ----------------------------------------------------------------
  always_comb begin
    addr_nxt      = addr_r;
    data_nxt      = data_r;
    irq_en_nxt    = irq_en_r;
    arm_nxt       = arm_r;
    arm_cnt_nxt   = arm_cnt_r;
    stall_cnt_nxt = stall_cnt_r;
    // Address held stable so the running write cannot be redirected
    if (bus.io_we && !busy_r) begin
      if (bus.io_addr == OFS_ADDRESS_HIGH) begin
        addr_nxt[8] = bus.io_wdata[0];
      end
      if (bus.io_addr == OFS_ADDRESS_LOW) begin
        addr_nxt[7:0] = bus.io_wdata;
      end
    end
    if (bus.io_we && (bus.io_addr == OFS_DATA_BYTE)) begin
      data_nxt = bus.io_wdata;
    end
    if (start_rd) begin
      data_nxt = mem_r[addr_r];
    end
    if (ctrl_wr) begin
      irq_en_nxt = bus.io_wdata[BIT_IRQ_ENABLE];
    end
    // A read-modify-write that echoes the arm bit does not restart its window
    if (ctrl_wr && bus.io_wdata[BIT_MASTER_ARM] && !arm_r) begin
      arm_nxt     = 1'b1;
      arm_cnt_nxt = 3'(ARM_CYCLES);
    end else if (start_wr) begin
      arm_nxt     = 1'b0;
      arm_cnt_nxt = 3'h0;
    end else if (arm_r) begin
      arm_cnt_nxt = arm_cnt_r - 3'h1;
      if (arm_cnt_r == 3'h1) begin
        arm_nxt = 1'b0;
      end
    end
    if (start_wr) begin
      stall_cnt_nxt = 3'(WRITE_STALL_CYCLES);
    end else if (start_rd) begin
      stall_cnt_nxt = 3'(READ_STALL_CYCLES);
    end else if (stall_cnt_r != 3'h0) begin
      stall_cnt_nxt = stall_cnt_r - 3'h1;
    end
    stall_nxt     = (stall_cnt_nxt != 3'h0);
    // Read strobe bit is never set, so polling always sees zero
    rd_strobe_nxt = 1'b0;
    // Level request with no flag: drops one cycle after a write starts, since it is registered from busy_r
    irq_nxt       = irq_en_r && bus.global_irq_enable && !busy_r;
    unique case (bus.io_addr)
      OFS_ADDRESS_HIGH: rdata_nxt = {7'h00, addr_r[8]};
      OFS_ADDRESS_LOW:  rdata_nxt = addr_r[7:0];
      OFS_DATA_BYTE:    rdata_nxt = data_r;
      OFS_CONTROL:      rdata_nxt = {4'h0, irq_en_r, arm_r, busy_r, rd_strobe_r};
    endcase
  end

  // ----------------------------------------------------------------
  // CPU-side registers: storage
  // ----------------------------------------------------------------
  // Address and data are cleared here, but software must not rely on it
  always_ff @(posedge i_clock) begin
    if (!i_resetn || !i_power_resetn) begin
      addr_r      <= ADDRESS_RESET;
      data_r      <= DATA_RESET;
      irq_en_r    <= 1'b0;
      arm_r       <= 1'b0;
      arm_cnt_r   <= 3'h0;
      rd_strobe_r <= 1'b0;
      stall_cnt_r <= 3'h0;
      stall_r     <= 1'b0;
      irq_r       <= 1'b0;
      rdata_r     <= 8'h00;
    end else if (i_enable) begin
      addr_r      <= addr_nxt;
      data_r      <= data_nxt;
      irq_en_r    <= irq_en_nxt;
      arm_r       <= arm_nxt;
      arm_cnt_r   <= arm_cnt_nxt;
      rd_strobe_r <= rd_strobe_nxt;
      stall_cnt_r <= stall_cnt_nxt;
      stall_r     <= stall_nxt;
      irq_r       <= irq_nxt;
      rdata_r     <= rdata_nxt;
    end
  end

  // ----------------------------------------------------------------
  // Write engine: next values
  // ----------------------------------------------------------------
  always_comb begin
    busy_nxt    = busy_r;
    wr_cnt_nxt  = wr_cnt_r;
    wr_addr_nxt = wr_addr_r;
    wr_data_nxt = wr_data_r;
    if (start_wr) begin
      busy_nxt    = 1'b1;
      wr_cnt_nxt  = CW'(WRITE_CYCLES);
      wr_addr_nxt = addr_r;
      wr_data_nxt = data_r;
    end else if (busy_r) begin
      wr_cnt_nxt = wr_cnt_r - CW'(1);
      if (commit) begin
        busy_nxt = 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Write engine: storage
  // ----------------------------------------------------------------
  // Only power-on reset stops the engine; system reset lets a write finish
  always_ff @(posedge i_clock) begin
    if (!i_power_resetn) begin
      busy_r    <= 1'b0;
      wr_cnt_r  <= '0;
      wr_addr_r <= ADDRESS_RESET;
      wr_data_r <= DATA_RESET;
    end else if (i_enable) begin
      busy_r    <= busy_nxt;
      wr_cnt_r  <= wr_cnt_nxt;
      wr_addr_r <= wr_addr_nxt;
      wr_data_r <= wr_data_nxt;
    end
  end

  // Array contents are nonvolatile: never reset
  always_ff @(posedge i_clock) begin
    if (i_enable && commit) begin
      mem_r[wr_addr_r] <= wr_data_r;
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign bus.io_rdata  = rdata_r;
  assign bus.cpu_stall = stall_r;
  assign bus.ready_irq = irq_r;
  // Timing oscillator request follows the write, whatever the sleep mode
  assign bus.osc_running = busy_r;

endmodule : nv_access_device

// File: core/nv_access_host.sv
// CPU-side controller: AXI4-Lite registers driving the nonvolatile store port
//
// Decided for this implementation: register access over AXI4-Lite and the register offsets.
`timescale 1ns/100ps
module nv_access_host
  import nv_pkg::*;
(
  input  wire logic        i_clock,
  input  wire logic        i_resetn,
  input  wire logic        i_enable,
  input  wire logic        i_awvalid,
  output logic             o_awready,
  input  wire logic [7:0]  i_awaddr,
  input  wire logic        i_wvalid,
  output logic             o_wready,
  input  wire logic [31:0] i_wdata,
  input  wire logic [3:0]  i_wstrb,
  output logic             o_bvalid,
  input  wire logic        i_bready,
  output logic [1:0]       o_bresp,
  input  wire logic        i_arvalid,
  output logic             o_arready,
  input  wire logic [7:0]  i_araddr,
  output logic             o_rvalid,
  input  wire logic        i_rready,
  output logic [31:0]      o_rdata,
  output logic [1:0]       o_rresp,
  nv_if.cpu                bus
);

  typedef enum logic [13:0] {
    S_IDLE  = 14'h0001, S_POLL  = 14'h0002, S_POLL2  = 14'h0004, S_CHECK = 14'h0008,
    S_ADDRH = 14'h0010, S_ADDRL = 14'h0020, S_DATA   = 14'h0040, S_ARM   = 14'h0080,
    S_STROB = 14'h0100, S_HOLD  = 14'h0200, S_WAIT   = 14'h0400, S_FETCH = 14'h0800,
    S_FETCH2 = 14'h1000, S_TAKE = 14'h2000
  } state_e;

  state_e      st_r, st_nxt;
  logic        is_rd_r, is_rd_nxt;
  logic [8:0]  addr_r, addr_nxt;
  logic [7:0]  wbyte_r, wbyte_nxt;
  logic [2:0]  cfg_r, cfg_nxt;
  logic [7:0]  rbyte_r, rbyte_nxt;
  logic [1:0]  ioa_r, ioa_nxt;
  logic [7:0]  iod_r, iod_nxt;
  logic        we_r, we_nxt, re_r, re_nxt, gie_r, gie_nxt, fl_r, fl_nxt;
  logic        aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic [7:0]  awaddr_r, awaddr_nxt;
  logic [31:0] wdat_r, wdat_nxt, mask;
  logic        awready_nxt, wready_nxt, bvalid_nxt, arready_nxt, rvalid_nxt;
  logic [1:0]  bresp_nxt, rresp_nxt;
  logic [31:0] rdata_nxt, wd;
  logic        aw_hs, w_hs, ar_hs, do_wr;
  logic [3:0]  ws, wstrb_r, wstrb_nxt;
  logic [7:0]  wa;

  // ----------------------------------------------------------------
  // Bus slave and sequencer: next values
  // ----------------------------------------------------------------
  always_comb begin
    aw_hs  = i_awvalid && o_awready;
    w_hs   = i_wvalid && o_wready;
    ar_hs  = i_arvalid && o_arready;
    wa     = aw_hs ? i_awaddr : awaddr_r;
    // Strobes are kept with the data, since the address may be taken later
    ws     = w_hs ? i_wstrb : wstrb_r;
    mask   = {{8{ws[3]}}, {8{ws[2]}}, {8{ws[1]}}, {8{ws[0]}}};
    wd     = (w_hs ? i_wdata : wdat_r) & mask;
    do_wr  = (aw_got_r || aw_hs) && (w_got_r || w_hs);
    aw_got_nxt = (aw_got_r || aw_hs) && !do_wr;
    w_got_nxt  = (w_got_r || w_hs) && !do_wr;
    awaddr_nxt = wa;
    wdat_nxt   = w_hs ? i_wdata : wdat_r;
    wstrb_nxt  = ws;
    bvalid_nxt = do_wr || (o_bvalid && !i_bready);
    bresp_nxt  = o_bresp;
    awready_nxt = !aw_got_nxt && !bvalid_nxt;
    wready_nxt  = !w_got_nxt && !bvalid_nxt;
    rvalid_nxt  = ar_hs || (o_rvalid && !i_rready);
    arready_nxt = !rvalid_nxt;
    rdata_nxt   = o_rdata;
    rresp_nxt   = o_rresp;
    addr_nxt  = addr_r;
    wbyte_nxt = wbyte_r;
    cfg_nxt   = cfg_r;
    st_nxt    = st_r;
    is_rd_nxt = is_rd_r;
    rbyte_nxt = rbyte_r;
    ioa_nxt   = ioa_r;
    iod_nxt   = iod_r;
    we_nxt    = 1'b0;
    re_nxt    = 1'b0;
    if (do_wr) begin
      bresp_nxt = RESP_OKAY;
      unique case (wa)
        REG_COMMAND: begin
          // Commands arriving while busy are dropped
          if (st_r == S_IDLE && (wd[CMD_WRITE] || wd[CMD_READ])) begin
            is_rd_nxt = !wd[CMD_WRITE];
            st_nxt    = S_POLL;
          end
        end
        REG_ADDRESS: addr_nxt  = (wd[8:0] & mask[8:0]) | (addr_r & ~mask[8:0]);
        REG_WDATA:   wbyte_nxt = (wd[7:0] & mask[7:0]) | (wbyte_r & ~mask[7:0]);
        REG_CONFIG:  cfg_nxt   = (wd[2:0] & mask[2:0]) | (cfg_r & ~mask[2:0]);
        REG_STATUS:  ;
        default:     bresp_nxt = RESP_SLVERR;
      endcase
    end
    if (ar_hs) begin
      rresp_nxt = RESP_OKAY;
      unique case (i_araddr)
        REG_ADDRESS: rdata_nxt = {23'h0, addr_r};
        REG_WDATA:   rdata_nxt = {24'h0, wbyte_r};
        REG_CONFIG:  rdata_nxt = {29'h0, cfg_r};
        REG_STATUS:  rdata_nxt = {16'h0, rbyte_r, 6'h0, bus.ready_irq, st_r != S_IDLE};
        REG_COMMAND: rdata_nxt = 32'h0;
        default: begin
          rdata_nxt = 32'h0;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end
    unique case (st_r)
      S_IDLE: ;
      S_POLL: begin
        ioa_nxt = OFS_CONTROL;
        re_nxt  = 1'b1;
        st_nxt  = S_POLL2;
      end
      S_POLL2: st_nxt = S_CHECK;
      S_CHECK: begin
        // Wait out a running write, and flash programming before a write
        if (bus.io_rdata[BIT_WRITE_STROBE] || (!is_rd_r && cfg_r[CFG_FLASH_BUSY])) begin
          st_nxt = S_POLL;
        end else begin
          st_nxt = S_ADDRH;
        end
      end
      S_ADDRH: begin
        ioa_nxt = OFS_ADDRESS_HIGH;
        iod_nxt = {7'h00, addr_r[8]};
        we_nxt  = 1'b1;
        st_nxt  = S_ADDRL;
      end
      S_ADDRL: begin
        ioa_nxt = OFS_ADDRESS_LOW;
        iod_nxt = addr_r[7:0];
        we_nxt  = 1'b1;
        st_nxt  = is_rd_r ? S_STROB : S_DATA;
      end
      S_DATA: begin
        ioa_nxt = OFS_DATA_BYTE;
        iod_nxt = wbyte_r;
        we_nxt  = 1'b1;
        st_nxt  = S_ARM;
      end
      S_ARM: begin
        ioa_nxt = OFS_CONTROL;
        iod_nxt = 8'(1 << BIT_MASTER_ARM);
        iod_nxt[BIT_IRQ_ENABLE] = cfg_r[CFG_IRQ_ENABLE];
        we_nxt  = 1'b1;
        st_nxt  = S_STROB;
      end
      S_STROB: begin
        // Strobe follows the arm write by one cycle, inside its window
        ioa_nxt = OFS_CONTROL;
        iod_nxt = is_rd_r ? 8'(1 << BIT_READ_STROBE) : 8'(1 << BIT_WRITE_STROBE);
        iod_nxt[BIT_IRQ_ENABLE] = cfg_r[CFG_IRQ_ENABLE];
        we_nxt  = 1'b1;
        st_nxt  = S_HOLD;
      end
      S_HOLD: st_nxt = S_WAIT;
      S_WAIT: begin
        if (!bus.cpu_stall) begin
          st_nxt = is_rd_r ? S_FETCH : S_IDLE;
        end
      end
      S_FETCH: begin
        ioa_nxt = OFS_DATA_BYTE;
        re_nxt  = 1'b1;
        st_nxt  = S_FETCH2;
      end
      S_FETCH2: st_nxt = S_TAKE;
      S_TAKE: begin
        rbyte_nxt = bus.io_rdata;
        st_nxt    = S_IDLE;
      end
    endcase
    // Interrupts masked for the whole sequence so the arm cannot time out
    gie_nxt = cfg_r[CFG_GIE] && (st_nxt == S_IDLE);
    fl_nxt  = cfg_r[CFG_FLASH_BUSY];
  end

  // ----------------------------------------------------------------
  // Storage
  // ----------------------------------------------------------------
  always_ff @(posedge i_clock) begin
    if (!i_resetn) begin
      st_r <= S_IDLE;   is_rd_r <= 1'b0;  addr_r <= ADDRESS_RESET;  wbyte_r <= DATA_RESET;
      cfg_r <= CONFIG_RESET;  rbyte_r <= 8'h00;  ioa_r <= OFS_ADDRESS_HIGH;  iod_r <= 8'h00;
      we_r <= 1'b0;  re_r <= 1'b0;  gie_r <= 1'b0;  fl_r <= 1'b0;
      aw_got_r <= 1'b0;  w_got_r <= 1'b0;  awaddr_r <= 8'h00;  wdat_r <= 32'h0;
      wstrb_r <= 4'h0;
      o_awready <= 1'b0;  o_wready <= 1'b0;  o_bvalid <= 1'b0;  o_bresp <= RESP_OKAY;
      o_arready <= 1'b0;  o_rvalid <= 1'b0;  o_rdata <= 32'h0;  o_rresp <= RESP_OKAY;
    end else if (i_enable) begin
      st_r <= st_nxt;   is_rd_r <= is_rd_nxt;  addr_r <= addr_nxt;  wbyte_r <= wbyte_nxt;
      cfg_r <= cfg_nxt;  rbyte_r <= rbyte_nxt;  ioa_r <= ioa_nxt;  iod_r <= iod_nxt;
      we_r <= we_nxt;  re_r <= re_nxt;  gie_r <= gie_nxt;  fl_r <= fl_nxt;
      aw_got_r <= aw_got_nxt;  w_got_r <= w_got_nxt;  awaddr_r <= awaddr_nxt;
      wdat_r <= wdat_nxt;
      wstrb_r <= wstrb_nxt;
      o_awready <= awready_nxt;  o_wready <= wready_nxt;  o_bvalid <= bvalid_nxt;
      o_bresp <= bresp_nxt;  o_arready <= arready_nxt;  o_rvalid <= rvalid_nxt;
      o_rdata <= rdata_nxt;  o_rresp <= rresp_nxt;
    end
  end

  assign bus.io_addr            = ioa_r;
  assign bus.io_wdata           = iod_r;
  assign bus.io_we              = we_r;
  assign bus.io_re              = re_r;
  assign bus.global_irq_enable  = gie_r;
  assign bus.flash_store_enable = fl_r;

endmodule : nv_access_host

// File: verification/nv_port_sva.sv
// Assertions on the register port between controller and store
`timescale 1ns/100ps
module nv_port_sva
  import nv_pkg::*;
#(
  parameter int unsigned WRITE_CYCLES = 40
) (
  input wire logic       i_clock,
  input wire logic       i_resetn,
  input wire logic       i_power_resetn,
  input wire logic [1:0] io_addr,
  input wire logic       io_we,
  input wire logic [7:0] io_rdata,
  input wire logic       cpu_stall,
  input wire logic       ready_irq,
  input wire logic       global_irq_enable,
  input wire logic       flash_store_enable,
  input wire logic       osc_running
);
  // -------------------------------------------------------------
  // Busy length counter
  // -------------------------------------------------------------
  // Only power reset clears it, since a write outlives system reset
  logic [31:0] busy_r;
  logic [31:0] busy_nxt;
  always_comb busy_nxt = osc_running ? busy_r + 32'h1 : 32'h0;
  always_ff @(posedge i_clock) busy_r <= i_power_resetn ? busy_nxt : 32'h0;
  default clocking cb @(posedge i_clock); endclocking
  default disable iff (!i_resetn);
  a_stall_len: assert property ($rose(cpu_stall) |-> cpu_stall[*2] ##1
    (!cpu_stall or cpu_stall[*2] ##1 !cpu_stall)) else $error("stall length");
  a_stall_cause: assert property ($rose(cpu_stall) |->
    $past(io_we) && $past(io_addr) == OFS_CONTROL) else $error("stall without strobe");
  a_ctrl_zero: assert property (io_addr == OFS_CONTROL |=>
    io_rdata[7:4] == 4'h0 && !io_rdata[0]) else $error("control spare bits");
  a_high_zero: assert property (io_addr == OFS_ADDRESS_HIGH |=> io_rdata[7:1] == 7'h00)
    else $error("address high spare bits");
  a_irq_gie: assert property (!$past(global_irq_enable) |-> !ready_irq)
    else $error("irq without global enable");
  a_irq_busy: assert property ($past(osc_running) |-> !ready_irq)
    else $error("irq while busy");
  a_flash_block: assert property ($rose(osc_running) |-> !$past(flash_store_enable))
    else $error("write during flash programming");
  a_busy_len: assert property (disable iff (!i_power_resetn)
    $fell(osc_running) |-> busy_r == WRITE_CYCLES) else $error("write length");
  a_gie_masked: assert property (cpu_stall |-> !global_irq_enable)
    else $error("interrupts open during access");
  c_write: cover property ($rose(osc_running));
  c_read_stall: cover property ($rose(cpu_stall) ##1 cpu_stall[*3]);
  c_irq: cover property ($rose(ready_irq));
endmodule : nv_port_sva

// File: verification/tb.sv
// Self-checking bench for controller and store joined by their port
`timescale 1ns/100ps
module tb;
  import nv_pkg::*;
  localparam int unsigned WC = 40;
  logic        clock = 1'b0, resetn = 1'b0, power_resetn = 1'b0;
  logic        awvalid = 1'b0, wvalid = 1'b0, bready = 1'b0, arvalid = 1'b0, rready = 1'b0;
  logic [7:0]  awaddr = 8'h00, araddr = 8'h00;
  logic [31:0] wdata = 32'h0, rd;
  logic        awready, wready, bvalid, arready, rvalid;
  logic [1:0]  bresp, rresp, resp;
  logic [31:0] rdata;
  int          err_count = 0, cmp_count = 0, cycles = 0;
`define CHK(nm, e, g) begin cmp_count++; if ((g) !== (e)) begin err_count++; \
  $display("wrong value %s exp %h got %h", nm, e, g); end end
  nv_if bus ();
  nv_access_host u_nv_access_host (.i_clock(clock), .i_resetn(resetn), .i_enable(1'b1),
    .i_awvalid(awvalid), .o_awready(awready), .i_awaddr(awaddr), .i_wvalid(wvalid),
    .o_wready(wready), .i_wdata(wdata), .i_wstrb(4'hf), .o_bvalid(bvalid), .i_bready(bready),
    .o_bresp(bresp), .i_arvalid(arvalid), .o_arready(arready), .i_araddr(araddr),
    .o_rvalid(rvalid), .i_rready(rready), .o_rdata(rdata), .o_rresp(rresp), .bus(bus));
  nv_access_device #(.WRITE_CYCLES(WC)) u_nv_access_device (.i_clock(clock),
    .i_resetn(resetn), .i_power_resetn(power_resetn), .i_enable(1'b1), .bus(bus));
  nv_port_sva #(.WRITE_CYCLES(WC)) u_nv_port_sva (.i_clock(clock), .i_resetn(resetn),
    .i_power_resetn(power_resetn), .io_addr(bus.io_addr), .io_we(bus.io_we),
    .io_rdata(bus.io_rdata), .cpu_stall(bus.cpu_stall), .ready_irq(bus.ready_irq),
    .global_irq_enable(bus.global_irq_enable), .flash_store_enable(bus.flash_store_enable),
    .osc_running(bus.osc_running));
  always #25 clock = ~clock;
  // -------------------------------------------------------------
  // Bus cycles
  // -------------------------------------------------------------
  task automatic axw(input logic [7:0] a, input logic [31:0] d);
    @(posedge clock);
    awaddr <= a;
    wdata <= d;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    bready <= 1'b1;
    do begin
      @(posedge clock);
      if (awready) awvalid <= 1'b0;
      if (wready) wvalid <= 1'b0;
    end while (bvalid !== 1'b1);
    bready <= 1'b0;
    resp = bresp;
  endtask : axw
  task automatic axr(input logic [7:0] a);
    @(posedge clock);
    araddr <= a;
    arvalid <= 1'b1;
    rready <= 1'b1;
    do begin
      @(posedge clock);
      if (arready) arvalid <= 1'b0;
    end while (rvalid !== 1'b1);
    rready <= 1'b0;
    rd = rdata;
    resp = rresp;
  endtask : axr
  task automatic idle();
    do axr(REG_STATUS); while (rd[ST_BUSY] !== 1'b0);
  endtask : idle
  task automatic nvw(input logic [8:0] a, input logic [7:0] d);
    axw(REG_ADDRESS, {23'h0, a});
    axw(REG_WDATA, {24'h0, d});
    axw(REG_COMMAND, 32'h1);
  endtask : nvw
  task automatic nvr(input logic [8:0] a, input logic [7:0] e);
    idle();
    axw(REG_ADDRESS, {23'h0, a});
    axw(REG_COMMAND, 32'h2);
    idle();
    `CHK("stored byte", e, rd[15:8])
  endtask : nvr
  // -------------------------------------------------------------
  // Scenarios
  // -------------------------------------------------------------
  task automatic t_ends();
    nvw(9'h000, 8'ha5);
    // Repeated command while the sequence runs is dropped
    axw(REG_COMMAND, 32'h1);
    `CHK("busy ack", RESP_OKAY, resp)
    nvr(9'h000, 8'ha5);
    nvw(9'h1ff, 8'h5a);
    nvr(9'h1ff, 8'h5a);
  endtask : t_ends
  task automatic t_irq();
    // The store's irq enable is loaded only by the control writes of a read or write sequence
    axw(REG_CONFIG, 32'h5);
    nvw(9'h010, 8'h11);
    idle();
    axr(REG_STATUS);
    `CHK("busy irq", 2'b00, rd[1:0])
    `CHK("osc on", 1'b1, bus.osc_running)
    repeat (WC) @(posedge clock);
    axr(REG_STATUS);
    `CHK("irq idle", 1'b1, rd[ST_IRQ])
    axw(REG_CONFIG, 32'h4);
    axr(REG_STATUS);
    `CHK("irq masked", 1'b0, rd[ST_IRQ])
  endtask : t_irq
  task automatic t_flash();
    axw(REG_CONFIG, 32'h2);
    nvw(9'h007, 8'h77);
    repeat (60) @(posedge clock);
    `CHK("flash block", 1'b0, bus.osc_running)
    axw(REG_CONFIG, 32'h0);
    nvr(9'h007, 8'h77);
  endtask : t_flash
  task automatic t_reset();
    nvw(9'h0a5, 8'h3c);
    repeat (14) @(posedge clock);
    resetn <= 1'b0;
    repeat (3) @(posedge clock);
    resetn <= 1'b1;
    axr(REG_CONFIG);
    `CHK("config reset", CONFIG_RESET, rd[2:0])
    nvr(9'h0a5, 8'h3c);
  endtask : t_reset
  task automatic t_unmapped();
    axw(8'h20, 32'h1);
    `CHK("unmapped write", RESP_SLVERR, resp)
    axr(8'h20);
    `CHK("unmapped read", {RESP_SLVERR, 32'h0}, {resp, rd})
  endtask : t_unmapped
  task automatic close_out();
    $display("errors %0d of %0d compares", err_count, cmp_count);
    if (err_count == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask : close_out
  always @(posedge clock) begin
    cycles <= cycles + 1;
    if (cycles == 30000) begin
      err_count++;
      close_out();
    end
  end
  initial begin
    repeat (16) @(posedge clock);
    resetn <= 1'b1;
    power_resetn <= 1'b1;
    t_ends();
    t_irq();
    t_flash();
    t_reset();
    t_unmapped();
    close_out();
  end
endmodule : tb
